// ===== logic/pdcfg_regs.sv
// Port power path status, hardware configuration and policy control registers
// Summary of operation
// - Power source field bits 39-38: 1h low-voltage input, 2h bus voltage.
// - Dead-battery set forces bus-voltage code in power source field.
// - Bit 34 shows cable-connector switch overcurrent while present.
// - Bit 28 shows internal five volt switch overcurrent while present.
// - Bits 14-12: external path off, fault, output, input.
// - Bits 8-6: internal five volt switch off, fault, output.
// - Bits 1-0: cable switch off, disabled, on CC1, on CC2.
// - Any hardware configuration change disconnects then reconnects port with new settings.
// - Variable-contract current limit: plus 25, 50, 75 mA or fixed 2900 mA.
// - Variable-contract source undervoltage threshold 90, 88, 92 percent.
// - Sink disconnect margin code picks 5 to 50 percent, reset 1h.
// - Five volt overvoltage limit 5.25 to 6.1 V, reset 2h.
// - Overvoltage trip scale 100, 105, 111, 114 percent, reset 2h.
// - Configuration bit 10 disables power delivery on the port.
// - Bits 9-8 select no optional state, Try.SRC or Try.SNK.
// - Bits 1-0 pick default state machine, reset dual-role.
// - Policy control writes act only when the policy next runs.
// - Bits 31-30 select legacy charger detection types.
// - Bits 28-26 select legacy charger emulation mode.
// - Bit 20 enables current monitoring and keeps active power mode.
// - Bit 19 advertises unconstrained power; falling edge blocks own role swap.
// - Bits 15,13 initiate data-role swaps; bits 14,12 accept them.
// - Dead-battery boot flag set when booted in dead-battery mode.
`timescale 1ns/1ps
module pdcfg_regs #(
    parameter int DISC_CYCLES = pdcfg_pkg::PDCFG_DISC_CYCLES // Disconnect hold, cycles
) (
    input wire logic core_clk_i,                       // Core clock, 50 MHz
    input wire logic reset_n_i,                        // Async reset, active low
    input wire logic frame_start_i,                    // Host frame begins
    input wire logic frame_end_i,                      // Host write frame ends
    input wire logic wr_valid_i,                       // Host byte present
    input wire logic [7:0] wr_data_i,                  // Host byte
    input wire logic rd_req_i,                         // Host asks for a byte
    output logic [7:0] rd_data_o,                      // Byte read back
    output logic rd_valid_o,                           // Read byte valid pulse
    input wire pdcfg_pkg::pdcfg_path_in_t path_i,      // Live power path state
    input wire logic policy_invoke_i,                  // Policy runs now
    output logic boot_dead_battery_o,                  // Dead-battery boot flag
    output logic port_disconnect_o,                    // Port held disconnected
    output logic port_reconnect_o,                     // Reconnect pulse
    output pdcfg_pkg::pdcfg_hwcfg_t hwcfg_o,           // Applied hardware settings
    output pdcfg_pkg::pdcfg_policy_t policy_o          // Applied policy settings
);
    import pdcfg_pkg::*;

    localparam logic [7:0] DISC_LAST = 8'(DISC_CYCLES - 1);

    logic [7:0] addr;
    logic wr_stb;
    logic [7:0] wr_idx;
    logic rd_stb;
    logic [7:0] rd_idx;

    logic [39:0] path_reg;
    logic [135:0] hwcfg_reg;
    logic [31:0] policy_reg;
    logic hwcfg_dirty;
    logic boot_seen;
    logic [31:0] hc_applied;
    pdcfg_rc_state_t rc_state;
    logic [7:0] disc_cnt;

    pdcfg_byte_port u_byte_port (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .frame_start_i(frame_start_i),
        .wr_valid_i(wr_valid_i),
        .wr_data_i(wr_data_i),
        .rd_req_i(rd_req_i),
        .addr_o(addr),
        .wr_stb_o(wr_stb),
        .wr_idx_o(wr_idx),
        .rd_stb_o(rd_stb),
        .rd_idx_o(rd_idx)
    );

    // Address decode
    wire sel_path = (addr == PDCFG_OFS_PATH);
    wire sel_hwcfg = (addr == PDCFG_OFS_HWCFG);
    wire sel_policy = (addr == PDCFG_OFS_POLICY);
    wire hwcfg_wr = wr_stb && sel_hwcfg && (wr_idx < PDCFG_LEN_HWCFG);
    wire policy_wr = wr_stb && sel_policy && (wr_idx < PDCFG_LEN_POLICY);
    wire [7:0] hwcfg_old = hwcfg_reg[wr_idx * 8 +: 8];

    wire next_boot_db = boot_seen ? boot_dead_battery_o : path_i.dead_battery;

    wire [1:0] src_code = (boot_dead_battery_o || path_i.vbus_powered) ?
        PDCFG_SRC_VBUS : PDCFG_SRC_LOWV;
    wire [2:0] ext_code = path_i.ext_fault ? PDCFG_SW_FAULT :
        !path_i.ext_en ? PDCFG_SW_OFF :
        path_i.ext_input ? PDCFG_SW_IN : PDCFG_SW_OUT;
    wire [2:0] int_code = path_i.int5v_fault ? PDCFG_SW_FAULT :
        path_i.int5v_en ? PDCFG_SW_OUT : PDCFG_SW_OFF;
    wire [1:0] cable_code = path_i.cable_fault ? PDCFG_CABLE_DIS :
        !path_i.cable_en ? PDCFG_CABLE_OFF :
        path_i.cable_cc2 ? PDCFG_CABLE_CC2 : PDCFG_CABLE_CC1;

    logic [39:0] next_path;
    always_comb
    begin
        next_path = 40'h0;
        next_path[PDCFG_PP_SRC_LSB +: 2] = src_code;
        next_path[PDCFG_PP_CABLE_OC_BIT] = path_i.cable_oc;
        next_path[PDCFG_PP_INT5V_OC_BIT] = path_i.int5v_oc;
        next_path[PDCFG_EXTERNAL_PATH_SWITCH_LSB +: 3] = ext_code;
        next_path[PDCFG_PP_INT5V_LSB +: 3] = int_code;
        next_path[PDCFG_PP_CABLE_LSB +: 2] = cable_code;
    end

    // Read selection, index 0 returns length
    wire [7:0] rd_len = sel_path ? PDCFG_LEN_PATH : sel_hwcfg ? PDCFG_LEN_HWCFG :
        sel_policy ? PDCFG_LEN_POLICY : 8'h00;
    wire [7:0] rd_byte_idx = rd_idx - 8'h01;
    wire rd_in_range = (rd_idx != 8'h00) && (rd_byte_idx < rd_len);
    wire [7:0] rd_sel = sel_path ? path_reg[rd_byte_idx[2:0] * 8 +: 8] :
        sel_hwcfg ? hwcfg_reg[rd_byte_idx[4:0] * 8 +: 8] :
        policy_reg[rd_byte_idx[1:0] * 8 +: 8];
    wire [7:0] next_rd_data = (rd_idx == 8'h00) ? rd_len : (rd_in_range ? rd_sel : 8'h00);

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            boot_seen <= 1'b0;
            boot_dead_battery_o <= 1'b0;
            path_reg <= 40'h0;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            boot_seen <= 1'b1;
            boot_dead_battery_o <= next_boot_db;
            path_reg <= next_path;
            rd_valid_o <= rd_stb;
            if (rd_stb)
            begin
                rd_data_o <= next_rd_data;
            end
        end
    end

    // Hardware configuration storage and change detection
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            hwcfg_reg <= PDCFG_HWCFG_RESET;
            hwcfg_dirty <= 1'b0;
        end
        else
        begin
            if (hwcfg_wr)
            begin
                hwcfg_reg[wr_idx * 8 +: 8] <= wr_data_i;
            end
            if (hwcfg_wr && hwcfg_old != wr_data_i)
            begin
                hwcfg_dirty <= 1'b1;
            end
            else if (frame_end_i)
            begin
                hwcfg_dirty <= 1'b0;
            end
        end
    end

    wire reconnect_req = frame_end_i && (hwcfg_dirty || (hwcfg_wr && hwcfg_old != wr_data_i));

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rc_state <= PDCFG_RC_IDLE;
            disc_cnt <= 8'h00;
            hc_applied <= PDCFG_HWCFG_RESET[31:0];
            port_disconnect_o <= 1'b0;
            port_reconnect_o <= 1'b0;
        end
        else
        begin
            port_reconnect_o <= 1'b0;
            if (reconnect_req)
            begin
                rc_state <= PDCFG_RC_DISC;
                disc_cnt <= 8'h00;
                port_disconnect_o <= 1'b1;
            end
            else
            begin
                unique case (rc_state)
                    PDCFG_RC_IDLE:
                    begin
                        port_disconnect_o <= 1'b0;
                    end
                    PDCFG_RC_DISC:
                    begin
                        disc_cnt <= disc_cnt + 8'h01;
                        if (disc_cnt == DISC_LAST)
                        begin
                            rc_state <= PDCFG_RC_APPLY;
                        end
                    end
                    PDCFG_RC_APPLY:
                    begin
                        hc_applied <= hwcfg_reg[31:0];
                        port_disconnect_o <= 1'b0;
                        port_reconnect_o <= 1'b1;
                        rc_state <= PDCFG_RC_IDLE;
                    end
                    default:
                    begin
                        rc_state <= PDCFG_RC_IDLE;
                    end
                endcase
            end
        end
    end

    // Applied hardware field codes
    wire [1:0] hc_cur = hc_applied[PDCFG_HC_CURMARGIN_LSB +: 2];
    wire [1:0] hc_uvp = hc_applied[PDCFG_HC_SRCUVP_LSB +: 2];
    wire [2:0] hc_sink = hc_applied[PDCFG_HC_SINKMARGIN_LSB +: 3];
    wire [1:0] hc_ovp5 = hc_applied[PDCFG_HC_OVP5V_LSB +: 2];
    wire [1:0] hc_ovps = hc_applied[PDCFG_HC_OVPSCALE_LSB +: 2];
    wire [1:0] hc_try = hc_applied[PDCFG_HC_TRY_LSB +: 2];

    assign hwcfg_o.cur_margin_code = hc_cur;
    assign hwcfg_o.cur_margin_ma = PDCFG_CUR_MARGIN_MA[hc_cur];
    assign hwcfg_o.cur_fixed_limit = (hc_cur == 2'h3);
    // source undervoltage, reserved code gives zero
    assign hwcfg_o.src_uvp_pct = PDCFG_SRC_UVP_PCT[hc_uvp];
    assign hwcfg_o.sink_margin_pct = PDCFG_SINK_MARGIN_PCT[hc_sink];
    assign hwcfg_o.ovp5v_10mv = PDCFG_OVP5V_10MV[hc_ovp5];
    assign hwcfg_o.ovp_scale_pct = PDCFG_OVP_SCALE_PCT[hc_ovps];
    assign hwcfg_o.pd_disable = hc_applied[PDCFG_HC_PDDIS_BIT];
    assign hwcfg_o.try_src = (hc_try == 2'h1);
    assign hwcfg_o.try_snk = (hc_try == 2'h2);
    assign hwcfg_o.typec_sm = hc_applied[PDCFG_HC_SM_LSB +: 2];

    // Policy control storage and deferred application
    logic [31:0] pc_applied;
    logic pr_block;
    wire uncon_new = policy_reg[PDCFG_PC_UNCON_BIT];
    wire uncon_old = pc_applied[PDCFG_PC_UNCON_BIT];

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            policy_reg <= PDCFG_POLICY_RESET;
            pc_applied <= PDCFG_POLICY_RESET;
            pr_block <= 1'b0;
        end
        else
        begin
            if (policy_wr)
            begin
                policy_reg[wr_idx[1:0] * 8 +: 8] <= wr_data_i;
            end
            // takes effect on next policy run
            if (policy_invoke_i)
            begin
                pc_applied <= policy_reg;
                if (uncon_old && !uncon_new)
                begin
                    pr_block <= 1'b1;
                end
                else if (uncon_new)
                begin
                    pr_block <= 1'b0;
                end
            end
        end
    end

    wire [1:0] pc_det = pc_applied[PDCFG_PC_DETECT_LSB +: 2];
    wire [2:0] pc_emu = pc_applied[PDCFG_PC_EMUL_LSB +: 3];

    // charger detection, reserved code detects none
    assign policy_o.detect_bc12 = (pc_det == 2'h1) || (pc_det == 2'h3);
    assign policy_o.detect_proprietary = (pc_det == 2'h3);
    // charger emulation, reserved codes emulate none
    assign policy_o.emul_cdp = (pc_emu == 3'h1);
    assign policy_o.emul_dcp = (pc_emu == 3'h2);
    assign policy_o.emul_auto1 = (pc_emu == 3'h5);
    assign policy_o.emul_auto2 = (pc_emu == 3'h6);
    assign policy_o.current_monitor = pc_applied[PDCFG_PC_CURMON_BIT];
    assign policy_o.stay_active = pc_applied[PDCFG_PC_CURMON_BIT];
    assign policy_o.unconstrained_power = uncon_old;
    assign policy_o.pr_swap_auto_block = pr_block;
    assign policy_o.init_swap_to_dfp = pc_applied[PDCFG_PC_INIT_DFP_BIT];
    assign policy_o.accept_swap_to_dfp = pc_applied[PDCFG_PC_ACC_DFP_BIT];
    assign policy_o.init_swap_to_ufp = pc_applied[PDCFG_PC_INIT_UFP_BIT];
    assign policy_o.accept_swap_to_ufp = pc_applied[PDCFG_PC_ACC_UFP_BIT];
endmodule : pdcfg_regs

// ===== shared/pdcfg_pkg.sv
// Shared constants and carriers for the port status and configuration registers
package pdcfg_pkg;
    // Register offsets
    localparam logic [7:0] PDCFG_OFS_PATH = 8'h26;
    localparam logic [7:0] PDCFG_OFS_HWCFG = 8'h28;
    localparam logic [7:0] PDCFG_OFS_POLICY = 8'h29;
    // Register lengths in bytes
    localparam logic [7:0] PDCFG_LEN_PATH = 8'h05;
    localparam logic [7:0] PDCFG_LEN_HWCFG = 8'h11;
    localparam logic [7:0] PDCFG_LEN_POLICY = 8'h04;
    // Reset values
    localparam logic [135:0] PDCFG_HWCFG_RESET = 136'h01220002;
    localparam logic [31:0] PDCFG_POLICY_RESET = 32'h00815152;
    // Power path status field positions
    localparam int PDCFG_PP_SRC_LSB = 38;
    localparam int PDCFG_PP_CABLE_OC_BIT = 34;
    localparam int PDCFG_PP_INT5V_OC_BIT = 28;
    localparam int PDCFG_EXTERNAL_PATH_SWITCH_LSB = 12;
    localparam int PDCFG_PP_INT5V_LSB = 6;
    localparam int PDCFG_PP_CABLE_LSB = 0;
    // Power source and switch state codes
    localparam logic [1:0] PDCFG_SRC_LOWV = 2'h1;
    localparam logic [1:0] PDCFG_SRC_VBUS = 2'h2;
    localparam logic [2:0] PDCFG_SW_OFF = 3'h0;
    localparam logic [2:0] PDCFG_SW_FAULT = 3'h1;
    localparam logic [2:0] PDCFG_SW_OUT = 3'h2;
    localparam logic [2:0] PDCFG_SW_IN = 3'h3;
    localparam logic [1:0] PDCFG_CABLE_OFF = 2'h0;
    localparam logic [1:0] PDCFG_CABLE_DIS = 2'h1;
    localparam logic [1:0] PDCFG_CABLE_CC1 = 2'h2;
    localparam logic [1:0] PDCFG_CABLE_CC2 = 2'h3;
    // Hardware configuration field positions
    localparam int PDCFG_HC_CURMARGIN_LSB = 29;
    localparam int PDCFG_HC_SRCUVP_LSB = 27;
    localparam int PDCFG_HC_SINKMARGIN_LSB = 24;
    localparam int PDCFG_HC_OVP5V_LSB = 20;
    localparam int PDCFG_HC_OVPSCALE_LSB = 16;
    localparam int PDCFG_HC_PDDIS_BIT = 10;
    localparam int PDCFG_HC_TRY_LSB = 8;
    localparam int PDCFG_HC_SM_LSB = 0;
    // Policy control field positions
    localparam int PDCFG_PC_DETECT_LSB = 30;
    localparam int PDCFG_PC_EMUL_LSB = 26;
    localparam int PDCFG_PC_CURMON_BIT = 20;
    localparam int PDCFG_PC_UNCON_BIT = 19;
    localparam int PDCFG_PC_INIT_DFP_BIT = 15;
    localparam int PDCFG_PC_ACC_DFP_BIT = 14;
    localparam int PDCFG_PC_INIT_UFP_BIT = 13;
    localparam int PDCFG_PC_ACC_UFP_BIT = 12;
    // Decode tables, indexed by field code
    localparam logic [11:0] PDCFG_CUR_MARGIN_MA [0:3] = '{12'h019, 12'h032, 12'h04b, 12'hb54};
    localparam logic [6:0] PDCFG_SRC_UVP_PCT [0:3] = '{7'h5a, 7'h58, 7'h5c, 7'h00};
    localparam logic [6:0] PDCFG_SINK_MARGIN_PCT [0:7] =
        '{7'h05, 7'h0a, 7'h0f, 7'h14, 7'h19, 7'h1e, 7'h28, 7'h32};
    localparam logic [9:0] PDCFG_OVP5V_10MV [0:3] = '{10'h20d, 10'h226, 10'h244, 10'h262};
    localparam logic [6:0] PDCFG_OVP_SCALE_PCT [0:3] = '{7'h64, 7'h69, 7'h6f, 7'h72};
    // Disconnect hold before new settings are applied
    localparam int PDCFG_CLK_PERIOD_NS = 20;
    localparam int PDCFG_DISC_TIME_NS = 1000;
    localparam int PDCFG_DISC_CYCLES = PDCFG_DISC_TIME_NS / PDCFG_CLK_PERIOD_NS;

    typedef struct packed {
        logic dead_battery;
        logic vbus_powered;
        logic cable_oc;
        logic cable_en;
        logic cable_cc2;
        logic cable_fault;
        logic int5v_oc;
        logic int5v_en;
        logic int5v_fault;
        logic ext_en;
        logic ext_input;
        logic ext_fault;
    } pdcfg_path_in_t;

    typedef struct packed {
        logic [1:0] cur_margin_code;
        logic [11:0] cur_margin_ma;
        logic cur_fixed_limit;
        logic [6:0] src_uvp_pct;
        logic [6:0] sink_margin_pct;
        logic [9:0] ovp5v_10mv;
        logic [6:0] ovp_scale_pct;
        logic pd_disable;
        logic try_src;
        logic try_snk;
        logic [1:0] typec_sm;
    } pdcfg_hwcfg_t;

    typedef struct packed {
        logic detect_bc12;
        logic detect_proprietary;
        logic emul_cdp;
        logic emul_dcp;
        logic emul_auto1;
        logic emul_auto2;
        logic current_monitor;
        logic stay_active;
        logic unconstrained_power;
        logic pr_swap_auto_block;
        logic init_swap_to_dfp;
        logic accept_swap_to_dfp;
        logic init_swap_to_ufp;
        logic accept_swap_to_ufp;
    } pdcfg_policy_t;

    typedef enum logic [1:0] {
        PDCFG_BP_ADDR = 2'b00,
        PDCFG_BP_COUNT = 2'b01,
        PDCFG_BP_DATA = 2'b10
    } pdcfg_bp_state_t;

    typedef enum logic [1:0] {
        PDCFG_RC_IDLE = 2'b00,
        PDCFG_RC_DISC = 2'b01,
        PDCFG_RC_APPLY = 2'b10
    } pdcfg_rc_state_t;
endpackage : pdcfg_pkg

// ===== logic/pdcfg_byte_port.sv
// Byte framing of host register accesses: address, count, then data bytes
`timescale 1ns/1ps
module pdcfg_byte_port (
    input wire logic core_clk_i,        // Core clock
    input wire logic reset_n_i,         // Async reset, active low
    input wire logic frame_start_i,     // New frame begins
    input wire logic wr_valid_i,        // Host byte present
    input wire logic [7:0] wr_data_i,   // Host byte
    input wire logic rd_req_i,          // Host asks for next byte
    output logic [7:0] addr_o,          // Register offset of frame
    output logic wr_stb_o,              // Data byte write strobe
    output logic [7:0] wr_idx_o,        // Data byte index
    output logic rd_stb_o,              // Read byte strobe
    output logic [7:0] rd_idx_o         // Read index, 0 is length
);
    import pdcfg_pkg::*;

    pdcfg_bp_state_t state;
    logic [7:0] count;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    wire take_byte = wr_valid_i && !frame_start_i;
    wire data_ok = (state == PDCFG_BP_DATA) && (wr_idx < count);

    assign wr_stb_o = take_byte && data_ok;
    assign wr_idx_o = wr_idx;
    assign rd_stb_o = rd_req_i && !frame_start_i;
    assign rd_idx_o = rd_idx;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= PDCFG_BP_ADDR;
            addr_o <= 8'h00;
            count <= 8'h00;
            wr_idx <= 8'h00;
            rd_idx <= 8'h00;
        end
        else if (frame_start_i)
        begin
            state <= PDCFG_BP_ADDR;
            wr_idx <= 8'h00;
            rd_idx <= 8'h00;
        end
        else
        begin
            if (take_byte)
            begin
                unique case (state)
                    PDCFG_BP_ADDR:
                    begin
                        addr_o <= wr_data_i;
                        state <= PDCFG_BP_COUNT;
                    end
                    PDCFG_BP_COUNT:
                    begin
                        count <= wr_data_i;
                        state <= PDCFG_BP_DATA;
                    end
                    PDCFG_BP_DATA:
                    begin
                        if (data_ok)
                        begin
                            wr_idx <= wr_idx + 8'h01;
                        end
                    end
                    default:
                    begin
                        state <= PDCFG_BP_ADDR;
                    end
                endcase
            end
            if (rd_stb_o && rd_idx != 8'hff)
            begin
                rd_idx <= rd_idx + 8'h01;
            end
        end
    end
endmodule : pdcfg_byte_port

// ===== tb/pdcfg_regs_assertions.sv
// Concurrent checks on the port register block outputs
`timescale 1ns/1ps
module pdcfg_regs_chk #(
    parameter int DISC_CYCLES = pdcfg_pkg::PDCFG_DISC_CYCLES // Disconnect hold, cycles
) (
    input wire logic core_clk_i, // Core clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic frame_start_i, // Frame begins
    input wire logic rd_req_i, // Read request
    input wire logic rd_valid_o, // Read byte valid
    input wire logic policy_invoke_i, // Policy runs
    input wire logic boot_dead_battery_o, // Boot flag
    input wire logic port_disconnect_o, // Port disconnected
    input wire logic port_reconnect_o, // Reconnect pulse
    input wire pdcfg_pkg::pdcfg_hwcfg_t hwcfg_o, // Applied settings
    input wire pdcfg_pkg::pdcfg_policy_t policy_o // Applied policy
);
    import pdcfg_pkg::*;
    logic [7:0] hold_cnt;
    // Length of the current disconnect
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            hold_cnt <= 8'h00;
        else
            hold_cnt <= port_disconnect_o ? hold_cnt + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_read_answer: assert property (rd_req_i && !frame_start_i |=> rd_valid_o)
        else $error("read request not answered");
    a_hold_len: assert property ($fell(port_disconnect_o) |-> hold_cnt >= DISC_CYCLES)
        else $error("disconnect too short");
    a_recon_pair: assert property ($fell(port_disconnect_o) |-> port_reconnect_o)
        else $error("no reconnect at end of disconnect");
    a_recon_cause: assert property (port_reconnect_o |-> $past(port_disconnect_o))
        else $error("reconnect without disconnect");
    a_hw_stable: assert property (!port_reconnect_o |-> $stable(hwcfg_o))
        else $error("settings changed outside reconnect");
    a_policy_wait: assert property (!$past(policy_invoke_i) |-> $stable(policy_o))
        else $error("policy changed without a policy run");
    a_fixed_limit: assert property
        (hwcfg_o.cur_fixed_limit == (hwcfg_o.cur_margin_code == 2'h3))
        else $error("fixed current limit mismatch");
    a_monitor_active: assert property (policy_o.stay_active == policy_o.current_monitor)
        else $error("active mode differs from monitor");
    a_boot_hold: assert property ($past(reset_n_i, 2) |-> $stable(boot_dead_battery_o))
        else $error("boot flag changed after boot");
endmodule : pdcfg_regs_chk
bind pdcfg_regs pdcfg_regs_chk #(.DISC_CYCLES(DISC_CYCLES)) u_chk (.core_clk_i, .reset_n_i,
    .frame_start_i, .rd_req_i, .rd_valid_o, .policy_invoke_i, .boot_dead_battery_o,
    .port_disconnect_o, .port_reconnect_o, .hwcfg_o, .policy_o);

// ===== tb/pdcfg_host_model.sv
// Host side model issuing byte frames to the register block
`timescale 1ns/1ps
module pdcfg_host_model (
    input wire logic core_clk_i, // Core clock
    input wire logic [7:0] rd_data_i, // Byte read back
    input wire logic rd_valid_i, // Read byte valid
    output logic frame_start_o, // Frame begins
    output logic frame_end_o, // Write frame ends
    output logic wr_valid_o, // Byte present
    output logic [7:0] wr_data_o, // Byte
    output logic rd_req_o // Read request
);
    initial {frame_start_o, frame_end_o, wr_valid_o, wr_data_o, rd_req_o} = '0;
    task automatic put(input logic [7:0] b);
        @(negedge core_clk_i);
        wr_valid_o = 1'b1;
        wr_data_o = b;
        @(negedge core_clk_i);
        wr_valid_o = 1'b0;
        wr_data_o = ~b;
    endtask : put
    task automatic get(output logic [7:0] b);
        int k;
        @(negedge core_clk_i);
        rd_req_o = 1'b1;
        @(negedge core_clk_i);
        rd_req_o = 1'b0;
        for (k = 0; k < 3 && rd_valid_i !== 1'b1; k++)
            @(negedge core_clk_i);
        b = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
    endtask : get
    task automatic open_frame(input logic [7:0] ofs);
        @(negedge core_clk_i);
        frame_start_o = 1'b1;
        @(negedge core_clk_i);
        frame_start_o = 1'b0;
        put(ofs);
    endtask : open_frame
    task automatic wr32(input logic [7:0] ofs, input logic [31:0] d);
        int i;
        open_frame(ofs);
        put(8'h04);
        for (i = 0; i < 4; i++)
            put(d[8*i+:8]);
        @(negedge core_clk_i);
        frame_end_o = 1'b1;
        @(negedge core_clk_i);
        frame_end_o = 1'b0;
    endtask : wr32
    task automatic rd40(input logic [7:0] ofs, output logic [7:0] len, output logic [39:0] v);
        int i;
        logic [7:0] b;
        open_frame(ofs);
        get(len);
        for (i = 0; i < 5; i++)
        begin
            get(b);
            v[8*i+:8] = b;
        end
    endtask : rd40
endmodule : pdcfg_host_model

// ===== tb/pdcfg_regs_test.sv
// Self-checking bench for the port register block
`timescale 1ns/1ps
module pdcfg_regs_test;
    import pdcfg_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic policy_invoke = 1'b0;
    logic frame_start, frame_end, wr_valid, rd_req, rd_valid, boot_db, disc, recon;
    logic [7:0] wr_data, rd_data, len;
    logic [39:0] v;
    pdcfg_path_in_t path = 12'h3b6;
    pdcfg_hwcfg_t hw;
    pdcfg_policy_t pol;
    int err_count = 0;
    int total_checks = 0;
    always #10 core_clk_i = ~core_clk_i;
    pdcfg_regs #(.DISC_CYCLES(2)) dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .frame_start_i(frame_start), .frame_end_i(frame_end), .wr_valid_i(wr_valid),
        .wr_data_i(wr_data), .rd_req_i(rd_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .path_i(path), .policy_invoke_i(policy_invoke), .boot_dead_battery_o(boot_db),
        .port_disconnect_o(disc), .port_reconnect_o(recon), .hwcfg_o(hw), .policy_o(pol));
    pdcfg_host_model host (.core_clk_i(core_clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .frame_start_o(frame_start), .frame_end_o(frame_end), .wr_valid_o(wr_valid),
        .wr_data_o(wr_data), .rd_req_o(rd_req));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic invoke();
        @(negedge core_clk_i);
        policy_invoke = 1'b1;
        @(negedge core_clk_i);
        policy_invoke = 1'b0;
        @(negedge core_clk_i);
    endtask : invoke
    task automatic t_reset_values();
        chk({hw.sink_margin_pct, hw.ovp5v_10mv, hw.ovp_scale_pct}, {7'h0a, 10'h244, 7'h6f});
        chk(hw.typec_sm, 2'h2);
        chk({pol.accept_swap_to_dfp, pol.accept_swap_to_ufp, pol.init_swap_to_dfp}, 3'h6);
        host.rd40(8'h29, len, v);
        chk({len, v}, {8'h04, 40'h00_0081_5152});
    endtask : t_reset_values
    task automatic t_status();
        host.wr32(8'h26, 32'hffff_ffff);
        host.rd40(8'h26, len, v);
        chk({len, v}, {8'h05, 40'h44_1000_3083});
        path = 12'h55d;
        host.rd40(8'h26, len, v);
        chk(v, 40'h80_0000_1041);
    endtask : t_status
    task automatic t_reconnect();
        int k;
        host.wr32(8'h28, 32'h6f31_0601);
        for (k = 0; k < 10 && disc !== 1'b1; k++)
            @(negedge core_clk_i);
        for (k = 0; k < 10 && disc === 1'b1; k++)
            @(negedge core_clk_i);
        chk({8'(k), 7'h0, recon}, {8'h03, 8'h01});
        chk({hw.cur_margin_ma, hw.src_uvp_pct}, {12'hb54, 7'h58});
        chk({hw.sink_margin_pct, hw.ovp5v_10mv, hw.ovp_scale_pct}, {7'h32, 10'h262, 7'h69});
        chk({hw.pd_disable, hw.try_src, hw.try_snk, hw.typec_sm}, 5'h15);
        host.wr32(8'h28, 32'h6f31_0601);
        chk({disc, recon}, 2'h0);
    endtask : t_reconnect
    task automatic t_policy();
        host.wr32(8'h29, 32'hd418_a000);
        chk(pol.accept_swap_to_dfp, 1'b1);
        invoke();
        chk({pol.detect_bc12, pol.detect_proprietary, pol.emul_auto1, pol.current_monitor,
            pol.unconstrained_power}, 5'h1f);
        chk({pol.init_swap_to_dfp, pol.accept_swap_to_dfp, pol.init_swap_to_ufp,
            pol.accept_swap_to_ufp}, 4'ha);
        host.wr32(8'h29, 32'hd810_a000);
        invoke();
        chk({pol.emul_auto2, pol.unconstrained_power, pol.pr_swap_auto_block}, 3'h5);
    endtask : t_policy
    task automatic t_dead_battery();
        path = 12'h800;
        reset_n_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        @(negedge core_clk_i);
        path = 12'h000;
        host.rd40(8'h26, len, v);
        chk({boot_db, v}, {1'b1, 40'h80_0000_0000});
    endtask : t_dead_battery
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (2) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        t_reset_values();
        t_status();
        t_reconnect();
        t_policy();
        t_dead_battery();
        end_of_test();
    end
    initial
    begin
        #100us;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule : pdcfg_regs_test
